// [pwm_sync_pkg.sv]
/*
 * constants shared by the synchronous pwm channel group block.
 * assumes a single 200 MHz clock and plain control ports, no register bus.
 */
// What this block does
// - a fault on any channel raises a fault interrupt, separate from end of period, only if enabled and unmasked.
// - reading the interrupt status clears the pending fault interrupt even while the fault stays active.
// - synchronous channels share one clock, period and alignment and start together so counters stay in step.
// - membership is one bit per channel in the sync mode register and only one group exists.
// - any member bit set makes channel 0 a member automatically.
// - members use channel 0 prescale, period and alignment, so their own settings do not change the outputs.
// - enabling or disabling channel 0 enables or disables every member at once.
// - a member other than channel 0 can still be enabled or disabled on its own.
// - with update method 1, period and dead-time apply after unlock, duty applies when the update period elapses.
// - while channel 0 is faulted, no enabled comparison unit reports a match.
package pwm_sync_pkg;
    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int          NUM_CHANNELS   = 4;
    localparam int          COUNT_WIDTH    = 16;
    localparam int          PRESCALE_WIDTH = 4;
    localparam int          UPR_WIDTH      = 4;
    localparam logic [15:0] COUNT_INIT     = 16'h0000;
    localparam logic [3:0]  UPR_RESET      = 4'h0;
    localparam logic        UPDATE_METHOD_SELECT_MANUAL    = 1'b0;
    localparam logic        UPDATE_METHOD_SELECT_AUTO_DUTY = 1'b1;
    localparam logic        ALIGN_LEFT     = 1'b0;
    localparam logic        ALIGN_CENTER   = 1'b1;
endpackage

// [pwm_channel_counter.sv]
/*
 * one pwm channel counter with prescaler, left or centre alignment and a period end flag.
 * assumes its settings are already resolved by the group logic.
 */
`timescale 1ns/1ps
module pwm_channel_counter
    import pwm_sync_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      run_in,
    input  wire logic                      restart_in,
    input  wire logic [PRESCALE_WIDTH-1:0] prescale_in,
    input  wire logic                      align_in,
    input  wire logic [COUNT_WIDTH-1:0]    period_in,
    output logic      [COUNT_WIDTH-1:0]    count_out,
    output logic                           period_end_out
);
    localparam int PW = 1 << PRESCALE_WIDTH;

    logic [PW-1:0] presc;
    logic          down;
    logic          tick;

    // prescaler ticks every 2^prescale clocks; its width covers the largest selection
    assign tick = ((presc & ((PW'(1) << prescale_in) - PW'(1))) == '0);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || restart_in || !run_in) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // counter; restart puts it back at the initial count on the common edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || restart_in || !run_in) begin
            count_out      <= COUNT_INIT;
            down           <= 1'b0;
            period_end_out <= 1'b0;
        end else begin
            period_end_out <= 1'b0;
            if (tick) begin
                if (align_in == ALIGN_LEFT) begin
                    down <= 1'b0;
                    if (count_out >= period_in) begin
                        count_out      <= COUNT_INIT;
                        period_end_out <= 1'b1;
                    end else begin
                        count_out <= count_out + 1'b1;
                    end
                end else if (!down) begin
                    if (count_out >= period_in) begin
                        down      <= 1'b1;
                        count_out <= count_out - 1'b1;
                    end else begin
                        count_out <= count_out + 1'b1;
                    end
                end else if (count_out == COUNT_INIT) begin
                    down           <= 1'b0;
                    period_end_out <= 1'b1;
                end else begin
                    count_out <= count_out - 1'b1;
                end
            end
        end
    end
endmodule

// [pwm_sync_channel_control.sv]
/*
 * synchronous channel group of a pwm controller: enables, settings of the
 * group, double buffered updates, compare outputs and the fault interrupt.
 * assumes software drives the one-cycle strobes from logic on clk_in; the
 * fault inputs come from pins and are synchronised here.
 */
`timescale 1ns/1ps
module pwm_sync_channel_control
    import pwm_sync_pkg::*;
#(
    parameter int N = NUM_CHANNELS
)(
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic [N-1:0]                enable_set_in,
    input  wire logic [N-1:0]                disable_set_in,
    input  wire logic [N-1:0]                group_member_bit_in,
    input  wire logic                        update_method_select_in,
    input  wire logic                        update_unlock_set_in,
    input  wire logic [UPR_WIDTH-1:0]        update_period_count_in,
    input  wire logic [N*PRESCALE_WIDTH-1:0] clock_prescale_select_in,
    input  wire logic [N-1:0]                alignment_select_in,
    input  wire logic [N*COUNT_WIDTH-1:0]    period_update_in,
    input  wire logic [N*COUNT_WIDTH-1:0]    duty_update_in,
    input  wire logic [N*COUNT_WIDTH-1:0]    deadtime_update_in,
    input  wire logic [N-1:0]                output_polarity_bit_in,
    input  wire logic [N-1:0]                compare_enable_in,
    input  wire logic [COUNT_WIDTH-1:0]      compare_value_in,
    input  wire logic [N-1:0]                fault_pin_in,
    input  wire logic [N-1:0]                fault_input_polarity_in,
    input  wire logic [N-1:0]                fault_protect_enable_in,
    input  wire logic                        fault_irq_enable_in,
    input  wire logic                        fault_irq_mask_in,
    input  wire logic                        irq_status_read_in,
    output logic      [N-1:0]                chan_enable_bit_out,
    output logic      [N-1:0]                member_out,
    output logic      [N-1:0]                pwm_out,
    output logic      [N-1:0]                compare_match_out,
    output logic      [N*COUNT_WIDTH-1:0]    deadtime_out,
    output logic                             unlock_pending_out,
    output logic      [N-1:0]                fault_status_out,
    output logic                             fault_irq_out
);
    // ----------------------------------------
    // checks and declarations
    // ----------------------------------------
    if (N < 2 || N > 16) begin : g_bad_count
        $error("channel count out of range");
    end

    logic [N-1:0]             member;
    logic [N-1:0]             enabled;
    logic [N-1:0]             fault_s1;
    logic [N-1:0]             fault_s2;
    logic [N-1:0]             fault_hit;
    logic                     fault_pend;
    logic                     unlock;
    logic [UPR_WIDTH-1:0]     upr_active;
    logic [UPR_WIDTH-1:0]     upr_cnt;
    logic [COUNT_WIDTH-1:0]   period  [N];
    logic [COUNT_WIDTH-1:0]   duty    [N];
    logic [COUNT_WIDTH-1:0]   count   [N];
    logic [N-1:0]             pend;
    logic [N-1:0]             restart;
    logic                     group_go;
    logic                     upd_edge;

    // member set with channel 0 added whenever any channel is in the group
    assign member   = (|group_member_bit_in) ? (group_member_bit_in | N'(1)) : '0;
    assign group_go = enable_set_in[0] && (|member) && !enabled[0];
    assign upd_edge = pend[0];

    // ----------------------------------------
    // enables
    // ----------------------------------------
    // disable wins over enable in the same cycle, the safe direction
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            enabled <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (disable_set_in[i] || (member[i] && disable_set_in[0] && i != 0)) begin
                    enabled[i] <= 1'b0;
                end else if (enable_set_in[i] || (member[i] && enable_set_in[0])) begin
                    enabled[i] <= 1'b1;
                end
            end
        end
    end

    // a group start clears every member counter on one edge
    always_comb begin
        for (int i = 0; i < N; i++) begin
            restart[i] = (member[i] && group_go) || (enable_set_in[i] && !enabled[i]);
        end
    end

    // ----------------------------------------
    // counters: members take channel 0 settings
    // ----------------------------------------
    for (genvar g = 0; g < N; g++) begin : chans
        logic [PRESCALE_WIDTH-1:0] psel;
        logic                      asel;
        logic [COUNT_WIDTH-1:0]    prd;
        assign psel = member[g] ? clock_prescale_select_in[0+:PRESCALE_WIDTH]
                                : clock_prescale_select_in[g*PRESCALE_WIDTH+:PRESCALE_WIDTH];
        assign asel = member[g] ? alignment_select_in[0] : alignment_select_in[g];
        assign prd  = member[g] ? period[0] : period[g];
        pwm_channel_counter u_cnt (
            .clk_in         (clk_in),
            .rst_n_in       (rst_n_in),
            .run_in         (enabled[g]),
            .restart_in     (restart[g]),
            .prescale_in    (psel),
            .align_in       (asel),
            .period_in      (prd),
            .count_out      (count[g]),
            .period_end_out (pend[g])
        );
    end

    // ----------------------------------------
    // update machinery
    // ----------------------------------------
    // unlock is held until the next period boundary of the group
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            unlock <= 1'b0;
        end else if (update_unlock_set_in) begin
            unlock <= 1'b1; // set wins over the clear at a boundary
        end else if (upd_edge) begin
            unlock <= 1'b0;
        end
    end

    // update period counter for the automatic duty method
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            upr_cnt    <= '0;
            upr_active <= UPR_RESET;
        end else if (upd_edge) begin
            if (upr_cnt >= upr_active) begin
                upr_cnt    <= '0;
                upr_active <= update_period_count_in;
            end else begin
                upr_cnt <= upr_cnt + 1'b1;
            end
        end
    end

    // active period, duty and dead-time registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < N; i++) begin
                period[i] <= '1;
                duty[i]   <= '0;
            end
            deadtime_out <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!member[i] || !enabled[0]) begin
                    period[i] <= period_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                    duty[i]   <= duty_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                    deadtime_out[i*COUNT_WIDTH+:COUNT_WIDTH] <= deadtime_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                end else if (upd_edge) begin
                    if (unlock) begin
                        period[i] <= period_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                        deadtime_out[i*COUNT_WIDTH+:COUNT_WIDTH] <= deadtime_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                    end
                    if ((update_method_select_in == UPDATE_METHOD_SELECT_MANUAL && unlock) ||
                        (update_method_select_in == UPDATE_METHOD_SELECT_AUTO_DUTY && upr_cnt >= upr_active)) begin
                        duty[i] <= duty_update_in[i*COUNT_WIDTH+:COUNT_WIDTH];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // fault detection and interrupt
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_s1 <= '0;
            fault_s2 <= '0;
        end else begin
            fault_s1 <= fault_pin_in;
            fault_s2 <= fault_s1;
        end
    end

    assign fault_hit = ~(fault_s2 ^ fault_input_polarity_in) & fault_protect_enable_in;

    // a new fault beats a status read in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_pend <= 1'b0;
        end else if (|(fault_hit & ~fault_status_out)) begin
            fault_pend <= 1'b1;
        end else if (irq_status_read_in) begin
            fault_pend <= 1'b0;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_enable_bit_out <= '0;
            member_out          <= '0;
            pwm_out             <= '0;
            compare_match_out   <= '0;
            unlock_pending_out  <= 1'b0;
            fault_status_out    <= '0;
            fault_irq_out       <= 1'b0;
        end else begin
            chan_enable_bit_out <= enabled;
            member_out          <= member;
            unlock_pending_out  <= unlock;
            fault_status_out    <= fault_hit;
            fault_irq_out       <= fault_pend && fault_irq_enable_in && !fault_irq_mask_in;
            for (int i = 0; i < N; i++) begin
                // a faulted channel is forced to its inactive level
                pwm_out[i] <= (enabled[i] && !fault_hit[i] && count[i] < duty[i]) ^ output_polarity_bit_in[i];
                compare_match_out[i] <= compare_enable_in[i] && enabled[0] && !fault_hit[0] &&
                                        count[0] == compare_value_in;
            end
        end
    end
endmodule

// [pwm_sync_channel_control_assertions.sv]
/* timing checks on the ports of the synchronous pwm group.
   assumes one clock and the synchronous active low reset. */
`timescale 1ns/1ps
module pwm_sync_channel_control_assertions
    import pwm_sync_pkg::*;
#(
    parameter int N = NUM_CHANNELS
)(
    input wire logic         clk_in,
    input wire logic         rst_n_in,
    input wire logic [N-1:0] enable_set_in,
    input wire logic [N-1:0] disable_set_in,
    input wire logic [N-1:0] fault_protect_enable_in,
    input wire logic         fault_irq_enable_in,
    input wire logic         fault_irq_mask_in,
    input wire logic         irq_status_read_in,
    input wire logic [N-1:0] chan_enable_bit_out,
    input wire logic [N-1:0] member_out,
    input wire logic [N-1:0] compare_match_out,
    input wire logic [N-1:0] fault_status_out,
    input wire logic         fault_irq_out
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_group_on; enable_set_in[0] && !disable_set_in[0] |-> ##2 chan_enable_bit_out[0]; endproperty
    property p_group_off; disable_set_in[0] |-> ##2 !chan_enable_bit_out[0]; endproperty
    // member must follow a lone channel 0 enable; stable membership avoids lag
    property p_member_on;
        enable_set_in == N'(1) && disable_set_in == '0 && member_out[1] && $stable(member_out)
            |-> ##2 chan_enable_bit_out[1];
    endproperty
    property p_solo_on; enable_set_in[1] && disable_set_in == '0 |-> ##2 chan_enable_bit_out[1]; endproperty
    property p_chan0_member; |member_out |-> member_out[0]; endproperty
    property p_irq_gate; $rose(fault_irq_out) |-> $past(fault_irq_enable_in) && !$past(fault_irq_mask_in); endproperty
    property p_irq_raise;
        $rose(fault_status_out[0]) && fault_protect_enable_in[0] && fault_irq_enable_in && !fault_irq_mask_in
            |-> ##[0:2] fault_irq_out;
    endproperty
    property p_irq_clear; irq_status_read_in && fault_irq_out && $stable(fault_status_out) |-> ##[1:2] !fault_irq_out;
    endproperty
    property p_no_match; fault_status_out[0] [*3] |-> compare_match_out == '0; endproperty
    a_group_on: assert property (p_group_on) else $error("group enable not seen");
    a_group_off: assert property (p_group_off) else $error("group disable not seen");
    a_member_on: assert property (p_member_on) else $error("member not enabled with channel 0");
    a_solo_on: assert property (p_solo_on) else $error("single enable not seen");
    a_chan0_member: assert property (p_chan0_member) else $error("channel 0 not member");
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while off or masked");
    a_irq_raise: assert property (p_irq_raise) else $error("fault interrupt missing");
    a_irq_clear: assert property (p_irq_clear) else $error("status read kept interrupt");
    a_no_match: assert property (p_no_match) else $error("match during channel 0 fault");
    c_group: cover property (enable_set_in[0] && member_out[1]);
    c_irq: cover property ($rose(fault_irq_out));
    c_read: cover property (irq_status_read_in && fault_irq_out);
endmodule

bind pwm_sync_channel_control pwm_sync_channel_control_assertions #(.N(N)) i_pwm_sync_channel_control_assertions (.*);

// [pwm_sync_channel_control_tb.sv]
/* self-checking bench for the synchronous pwm group.
   assumes the design drives nothing back and uses the package sizes. */
`timescale 1ns/1ps
module pwm_sync_channel_control_tb;
    import pwm_sync_pkg::*;
    localparam int N = NUM_CHANNELS;
    logic                        clk_in, rst_n_in, update_method_select_in, update_unlock_set_in, irq_status_read_in;
    logic                        fault_irq_enable_in, fault_irq_mask_in, unlock_pending_out, fault_irq_out;
    logic [N-1:0]                enable_set_in, disable_set_in, group_member_bit_in, alignment_select_in;
    logic [N-1:0]                output_polarity_bit_in, compare_enable_in, fault_pin_in, fault_input_polarity_in;
    logic [N-1:0]                fault_protect_enable_in, chan_enable_bit_out, member_out, pwm_out;
    logic [N-1:0]                compare_match_out, fault_status_out, en_model, mem;
    logic [UPR_WIDTH-1:0]        update_period_count_in;
    logic [N*PRESCALE_WIDTH-1:0] clock_prescale_select_in;
    logic [N*COUNT_WIDTH-1:0]    period_update_in, duty_update_in, deadtime_update_in, deadtime_out;
    logic [COUNT_WIDTH-1:0]      compare_value_in, dt, dt_held;
    int                          bad_count, cmp_count, cycles;

    pwm_sync_channel_control #(.N(N)) i_pwm_sync_channel_control (.*);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // channel 0 joins as soon as anyone is a member
    function automatic logic [N-1:0] grp_of(input logic [N-1:0] m);
        return (m != '0) ? (m | N'(1)) : '0;
    endfunction
    // disable wins over enable in the same cycle
    function automatic logic [N-1:0] next_en(input logic [N-1:0] en, ena, dis, m);
        if (ena[0]) ena = ena | grp_of(m);
        if (dis[0]) dis = dis | grp_of(m);
        return (en | ena) & ~dis;
    endfunction
    // starts on an edge so the strobe is driven on the rising edge
    task automatic strobe(input logic [N-1:0] ena, input logic [N-1:0] dis);
        tick(1);
        enable_set_in <= ena;
        disable_set_in <= dis;
        tick(1);
        enable_set_in <= '0;
        disable_set_in <= '0;
        en_model = next_en(en_model, ena, dis, mem);
        tick(3);
        #1;
        check(chan_enable_bit_out, en_model);
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk_in);
            cycles++;
            if (cycles == 3000) begin
                bad_count++;
                tally_and_finish();
            end
        end
    end
    initial begin
        void'($urandom(32'h1C11));
        {rst_n_in, enable_set_in, disable_set_in, group_member_bit_in, update_unlock_set_in} = '0;
        {update_method_select_in, irq_status_read_in, fault_pin_in, fault_protect_enable_in} = '0;
        {fault_irq_mask_in, alignment_select_in, output_polarity_bit_in, clock_prescale_select_in} = '0;
        // channel 1 own settings differ; they must not matter while it is a member
        alignment_select_in[1] = 1'b1;
        clock_prescale_select_in[7:4] = 4'($urandom) | 4'h1;
        {fault_irq_enable_in, compare_enable_in, fault_input_polarity_in} = '1;
        update_period_count_in = 4'h2;
        period_update_in = {N{16'h0008}};
        duty_update_in = {N{16'h0004}};
        deadtime_update_in = '0;
        compare_value_in = 16'h0003;
        {en_model, mem, bad_count, cmp_count} = '0;
        dt_held = '0;
        tick(4);
        rst_n_in <= 1'b1;
        tick(1);
        #1;
        check({chan_enable_bit_out, member_out, fault_irq_out}, 0);
        // membership only changes once everything reads disabled
        for (int k = 0; k < 3; k++) begin
            tick(1);
            mem = (k == 0) ? 4'h6 : N'($urandom);
            group_member_bit_in <= mem;
            tick(3);
            #1;
            check(member_out, grp_of(mem));
            strobe(4'h1, 4'h0);
            strobe(4'h0, 4'h4);
            strobe(4'h3, 4'h2);
            repeat (8) strobe(N'($urandom), N'($urandom));
            strobe(4'h0, '1);
        end
        tick(1);
        mem = 4'h3;
        group_member_bit_in <= mem;
        for (int m = 0; m < 2; m++) begin
            tick(1);
            update_method_select_in <= m[0];
            alignment_select_in[0] <= m[0]; // centre alignment on the second pass
            strobe(4'h1, 4'h0);
            tick(1);
            dt = 16'h0010 + 16'(m);
            deadtime_update_in[16+:16] <= dt + 16'h0001;
            deadtime_update_in[48+:16] <= dt;
            // members started on one edge keep identical waveforms
            repeat (20) begin
                tick(1);
                #1;
                check(pwm_out[1], pwm_out[0]);
            end
            // members hold the last applied value until unlock
            check(deadtime_out[16+:16], dt_held);
            check(deadtime_out[48+:16], dt);
            tick(1);
            update_unlock_set_in <= 1'b1;
            tick(1);
            update_unlock_set_in <= 1'b0;
            tick(20);
            #1;
            check({unlock_pending_out, deadtime_out[16+:16]}, {1'b0, dt + 16'h0001});
            dt_held = dt + 16'h0001;
            strobe(4'h0, 4'h1);
        end
        strobe(4'h1, 4'h0);
        tick(1);
        fault_protect_enable_in <= '1;
        fault_pin_in[0] <= 1'b1;
        tick(6);
        #1;
        check({fault_status_out[0], fault_irq_out, compare_match_out}, {2'b11, 4'h0});
        tick(1);
        irq_status_read_in <= 1'b1;
        tick(1);
        irq_status_read_in <= 1'b0;
        tick(3);
        #1;
        check(fault_irq_out, 0);
        tick(1);
        fault_irq_mask_in <= 1'b1;
        fault_pin_in[1] <= 1'b1;
        tick(6);
        #1;
        check({fault_status_out[1], fault_irq_out}, 2'b10);
        tally_and_finish();
    end
endmodule
